// file: verilog/program_counter_stack.sv
// one 4-bit program counter stack slice, device end of the link
// assumes every link pin is asynchronous to clk_sys and sampled twice
//
// Notes on behaviour
// - 16x4 stack RAM, pointer addresses current counter
// - fetch drives current counter onto address bus
// - fetch stores counter plus one unless carry high
// - controller presents instruction, execute during clock high
// - latches follow RAM while clock high; enable gates output
// - fetch writes incrementer only while clock, execute low
// - address bus driven only while clock, execute low
// - carry out low at all ones with carry in
// - branch writes data into current location, pointer kept
// - address bus disabled for branch, call, return
// - call addresses pointer plus one once execute low
// - call output shows latches captured at falling clock
// - call writes data into new location during low
// - call registers incremented pointer at rising clock
// - full low at 1111; further call wraps to 0000
// - return addresses pointer minus one once execute low
// - return shows popped value early if execute early
// - return registers decremented pointer at rising clock
// - empty low at 0000; further return wraps to 1111
// - master reset clears pointer and entry zero, overrides
// - slices chain carries; lowest carry in tied low; the one slice here takes carry in from auto_inc
// - data in and out active low, address bus true
module program_counter_stack (
  input  wire logic    clk_sys,
  input  wire logic    reset_n,
  stack_link_if.device link
);
  typedef struct packed {
    logic [1:0]                    cp_p;
    logic [1:0]                    ex_p;
    logic [1:0]                    ih_p;
    logic [1:0]                    il_p;
    logic [1:0]                    ci_p;
    logic [1:0]                    mr_p;
    logic [1:0]                    oe_p;
    logic [1:0][3:0]               d_p;
    logic                          cp_prev;
    logic                          ex_prev;
    logic [1:0]                    op_prev;
    logic [3:0]                    sp;
    logic [15:0][3:0]              ram;
    logic [3:0]                    latch;
    logic [3:0]                    out_n;
    logic                          out_oe;
    logic [3:0]                    x;
    logic                          x_oe;
    logic                          co_n;
    logic                          sf_n;
    logic                          se_n;
  } dev_state_t;

  dev_state_t q;
  dev_state_t d;

  logic                cp;
  logic                ex;
  logic                ci_n;
  logic                mr;
  logic [3:0]          din;
  pc_stack_pkg::op_t   op;
  pc_stack_pkg::op_t   op_last;
  logic [3:0]          addr;
  logic                wr;
  logic                rise;
  logic [3:0]          flag_addr;

  // only the second sync stage is ever read
  always_comb
  begin
    cp      = q.cp_p[1];
    ex      = ~q.ex_p[1];
    ci_n    = q.ci_p[1];
    mr      = ~q.mr_p[1];
    din     = ~q.d_p[1];
    op      = pc_stack_pkg::op_t'({q.ih_p[1], q.il_p[1]});
    op_last = pc_stack_pkg::op_t'(q.op_prev);
    rise    = cp && !q.cp_prev;
    wr      = !cp && ex;
    addr    = q.sp;
    if (ex && op == pc_stack_pkg::OP_CALL)
      addr = q.sp + 4'h1;
    else if (ex && op == pc_stack_pkg::OP_RETURN)
      addr = q.sp - 4'h1;
  end

  always_comb
  begin
    d = q;
    d.cp_p    = {q.cp_p[0], link.clk};
    d.ex_p    = {q.ex_p[0], link.execute_n};
    d.ih_p    = {q.ih_p[0], link.instr_bit_high};
    d.il_p    = {q.il_p[0], link.instr_bit_low};
    d.ci_p    = {q.ci_p[0], link.carry_in_n};
    d.mr_p    = {q.mr_p[0], link.master_reset_n};
    d.oe_p    = {q.oe_p[0], link.out_enable_n};
    d.d_p     = {q.d_p[0], link.data_in_n};
    d.cp_prev = cp;
    d.ex_prev = ex;
    d.op_prev = op;

    // hold what was seen at the fall
    if (cp)
      d.latch = q.ram[addr];

    unique case (op)
      pc_stack_pkg::OP_FETCH:
      begin
        // write only in the low/low window
        // carry in high means iterative fetch
        // rewriting latch+1 each cycle is safe: latch holds
        if (wr)
          d.ram[q.sp] = q.latch + {3'h0, ~ci_n};
      end
      pc_stack_pkg::OP_BRANCH:
      begin
        if (wr)
          d.ram[q.sp] = din;
      end
      pc_stack_pkg::OP_CALL:
      begin
        if (wr)
          d.ram[addr] = din;
      end
      pc_stack_pkg::OP_RETURN:
      begin
      end
    endcase

    // execute and instruction taken from the low phase, since
    // the controller may release them on the same rising edge
    // pointer registered on rising clock
    if (rise && q.ex_prev)
    begin
      if (op_last == pc_stack_pkg::OP_CALL)
        d.sp = q.sp + 4'h1;
      else if (op_last == pc_stack_pkg::OP_RETURN)
        d.sp = q.sp - 4'h1;
    end
    // new pointer's data shown on rise
    if (rise && q.ex_prev && op_last == pc_stack_pkg::OP_CALL)
      d.latch = q.ram[q.sp + 4'h1];
    if (rise && q.ex_prev && op_last == pc_stack_pkg::OP_RETURN)
      d.latch = q.ram[q.sp - 4'h1];

    // master reset overrides pointer, entry zero and latch; other RAM writes still go on
    if (mr)
    begin
      d.sp                            = pc_stack_pkg::PTR_RESET;
      d.ram[pc_stack_pkg::PTR_RESET]  = 4'h0;
      d.latch                         = 4'h0;
    end

    // output bus active low, address bus true
    d.out_n  = ~d.latch;
    // output bus driven only with enable low
    d.out_oe = ~q.oe_p[1];
    d.x      = q.latch;
    // address drivers only in low/low fetch
    // never for the other three operations
    d.x_oe   = wr && op == pc_stack_pkg::OP_FETCH && !mr;
    // carry out from current counter and carry in
    d.co_n   = !(q.ram[q.sp] == pc_stack_pkg::PC_MAX && !ci_n);
    // execute and clock sync together, so at the rise the pointer is
    // already new: using the old one would glitch the flags for a cycle
    flag_addr = ex ? addr : d.sp;
    d.sf_n   = mr || !(flag_addr == pc_stack_pkg::PTR_TOP);
    d.se_n   = !mr && !(flag_addr == pc_stack_pkg::PTR_BOTTOM);

    if (!reset_n)
    begin
      d       = '0;
      d.out_n = 4'hf;
      d.co_n  = 1'b1;
      d.sf_n  = 1'b1;
      d.cp_p  = 2'h3;
      d.ex_p  = 2'h3;
      d.mr_p  = 2'h3;
      d.oe_p  = 2'h3;
      d.ci_p  = 2'h3;
      d.d_p   = 8'hff;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    q <= d;
  end

  assign link.stack_out_n    = q.out_n;
  assign link.stack_out_oe   = q.out_oe;
  assign link.fetch_addr_out = q.x;
  assign link.fetch_addr_oe  = q.x_oe;
  assign link.carry_out_n    = q.co_n;
  assign link.stack_full_n   = q.sf_n;
  assign link.stack_empty_n  = q.se_n;
endmodule

// file: verilog/pc_stack_pkg.sv
// constants shared by both ends of the program counter stack slice link
// assumes one system clock at 250 MHz on both ends
package pc_stack_pkg;
  localparam int unsigned CLK_SYS_NS  = 4;
  // link clock phases, as printed
  localparam int unsigned CP_HIGH_NS  = 40;
  localparam int unsigned CP_LOW_NS   = 40;
  // least times round up
  localparam int unsigned CP_HIGH_CYC = (CP_HIGH_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam int unsigned CP_LOW_CYC  = (CP_LOW_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam logic [7:0]  CP_LAST     = 8'(CP_HIGH_CYC + CP_LOW_CYC - 1);
  localparam logic [7:0]  CP_FALL     = 8'(CP_HIGH_CYC);
  localparam logic [7:0]  CNT_RESET   = 8'h00;

  localparam int unsigned DEPTH       = 16;
  localparam int unsigned WIDTH       = 4;
  localparam logic [3:0]  PTR_RESET   = 4'h0;
  localparam logic [3:0]  PTR_TOP     = 4'hf;
  localparam logic [3:0]  PTR_BOTTOM  = 4'h0;
  localparam logic [3:0]  PC_MAX      = 4'hf;

  // {high bit, low bit}
  typedef enum logic [1:0] {
    OP_RETURN = 2'h0,
    OP_BRANCH = 2'h1,
    OP_CALL   = 2'h2,
    OP_FETCH  = 2'h3
  } op_t;
endpackage

// file: verilog/stack_link_if.sv
// pins between one stack slice and its microprogram controller
// assumes both ends share clk_sys; three-state outputs carry enables
interface stack_link_if;
  logic       clk;
  logic       execute_n;
  logic       instr_bit_high;
  logic       instr_bit_low;
  logic       master_reset_n;
  logic       carry_in_n;
  logic       out_enable_n;
  logic [3:0] data_in_n;
  logic [3:0] stack_out_n;
  logic       stack_out_oe;
  logic [3:0] fetch_addr_out;
  logic       fetch_addr_oe;
  logic       carry_out_n;
  logic       stack_full_n;
  logic       stack_empty_n;

  modport device (
    input  clk,
    input  execute_n,
    input  instr_bit_high,
    input  instr_bit_low,
    input  master_reset_n,
    input  carry_in_n,
    input  out_enable_n,
    input  data_in_n,
    output stack_out_n,
    output stack_out_oe,
    output fetch_addr_out,
    output fetch_addr_oe,
    output carry_out_n,
    output stack_full_n,
    output stack_empty_n
  );

  modport controller (
    output clk,
    output execute_n,
    output instr_bit_high,
    output instr_bit_low,
    output master_reset_n,
    output carry_in_n,
    output out_enable_n,
    output data_in_n,
    input  stack_out_n,
    input  stack_out_oe,
    input  fetch_addr_out,
    input  fetch_addr_oe,
    input  carry_out_n,
    input  stack_full_n,
    input  stack_empty_n
  );
endinterface

// file: verilog/stack_controller.sv
// microprogram controller end: makes the link clock, issues one
// instruction per link clock period, collects fetched addresses
// assumes the device answers within one link period
module stack_controller (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_op,
  input  wire logic [3:0]  cmd_data,
  input  wire logic        cmd_clear,
  input  wire logic        auto_inc,
  input  wire logic        read_enable,
  output logic             cmd_ready,
  output logic             cmd_refused,
  output logic             fetch_valid,
  output logic [3:0]       fetch_addr,
  output logic [3:0]       stack_top,
  output logic             full,
  output logic             empty,
  stack_link_if.controller link
);
  typedef struct packed {
    logic [7:0]       cnt;
    logic             cp;
    logic             ex_n;
    logic [1:0]       op;
    logic [3:0]       d_n;
    logic             ci_n;
    logic             mr_n;
    logic             oe_n;
    logic [1:0]       xoe_p;
    logic [1:0][3:0]  x_p;
    logic [1:0][3:0]  o_p;
    logic [1:0]       sf_p;
    logic [1:0]       se_p;
    logic             xoe_prev;
    logic             ready;
    logic             refused;
    logic             fvalid;
    logic [3:0]       faddr;
    logic [3:0]       top;
    logic             full;
    logic             empty;
  } ctl_state_t;

  ctl_state_t q;
  ctl_state_t d;

  always_comb
  begin
    d = q;
    d.xoe_p    = {q.xoe_p[0], link.fetch_addr_oe};
    d.x_p      = {q.x_p[0], link.fetch_addr_out};
    d.o_p      = {q.o_p[0], link.stack_out_n};
    d.sf_p     = {q.sf_p[0], link.stack_full_n};
    d.se_p     = {q.se_p[0], link.stack_empty_n};
    d.xoe_prev = q.xoe_p[1];
    d.ci_n     = ~auto_inc;
    d.oe_n     = ~read_enable;
    d.refused  = 1'b0;
    d.fvalid   = 1'b0;
    d.full     = ~q.sf_p[1];
    d.empty    = ~q.se_p[1];
    d.top      = ~q.o_p[1];
    d.cnt      = q.cnt + 8'h1;
    if (q.cnt == pc_stack_pkg::CP_FALL)
      d.cp = 1'b0;
    if (q.cnt == pc_stack_pkg::CP_LAST)
    begin
      // new period: execute and instruction change with the rise
      d.cnt  = pc_stack_pkg::CNT_RESET;
      d.cp   = 1'b1;
      d.ex_n = 1'b1;
      d.mr_n = 1'b1;
      if (cmd_valid)
      begin
        d.op  = cmd_op;
        d.d_n = ~cmd_data;
        d.mr_n = ~cmd_clear;
        // no call while the stack is full
        // no return while the stack is empty
        if ((cmd_op == pc_stack_pkg::OP_CALL && q.full) ||
            (cmd_op == pc_stack_pkg::OP_RETURN && q.empty))
          d.refused = 1'b1;
        else
          // execute asserted for the whole period, through both high and low phase
          d.ex_n = 1'b0;
      end
    end
    d.ready = (d.cnt == pc_stack_pkg::CP_LAST);
    if (q.xoe_p[1])
      d.faddr = q.x_p[1];
    if (q.xoe_prev && !q.xoe_p[1])
      d.fvalid = 1'b1;
    if (!reset_n)
    begin
      d       = '0;
      d.cp    = 1'b1;
      d.ex_n  = 1'b1;
      d.mr_n  = 1'b1;
      d.oe_n  = 1'b1;
      d.d_n   = 4'hf;
      d.sf_p  = 2'h3;
      d.o_p   = 8'hff;
      d.top   = 4'h0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    q <= d;
  end

  assign link.clk            = q.cp;
  assign link.execute_n      = q.ex_n;
  assign link.instr_bit_high = q.op[1];
  assign link.instr_bit_low  = q.op[0];
  assign link.data_in_n      = q.d_n;
  // single slice, carry in from auto increment choice
  assign link.carry_in_n     = q.ci_n;
  assign link.master_reset_n = q.mr_n;
  assign link.out_enable_n   = q.oe_n;
  assign cmd_ready           = q.ready;
  assign cmd_refused         = q.refused;
  assign fetch_valid         = q.fvalid;
  assign fetch_addr          = q.faddr;
  assign stack_top           = q.top;
  assign full                = q.full;
  assign empty               = q.empty;
endmodule

// file: test/stack_link_checker.sv
// assertions on the link between the controller and the stack slice
// assumes link pins seen on clk_sys, reset_n synchronous active low
module stack_link_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk,
  input wire logic execute_n,
  input wire logic instr_bit_high,
  input wire logic instr_bit_low,
  input wire logic master_reset_n,
  input wire logic carry_in_n,
  input wire logic out_enable_n,
  input wire logic stack_out_oe,
  input wire logic fetch_addr_oe,
  input wire logic carry_out_n,
  input wire logic stack_full_n,
  input wire logic stack_empty_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fw;
  assign fw = !clk && !execute_n && instr_bit_high && instr_bit_low;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // device syncs each pin twice, so margins of a few cycles
  sequence fetch_low;
    fw [*6];
  endsequence
  a_addr_gate: assert property (
    fetch_addr_oe |-> $past(fw, 2) || $past(fw, 3) || $past(fw, 4) || $past(fw, 5))
    else $error("address bus driven outside fetch low phase");
  a_addr_on: assert property (fetch_low |-> fetch_addr_oe)
    else $error("address bus idle in fetch low phase");
  a_carry_idle: assert property (carry_in_n [*6] |-> carry_out_n)
    else $error("carry out low with carry in high");
  a_bus_off: assert property (out_enable_n [*5] |-> !stack_out_oe)
    else $error("output bus driven while disabled");
  a_bus_on: assert property (!out_enable_n [*5] |-> stack_out_oe)
    else $error("output bus not driven while enabled");
  a_reset_empty: assert property (
    !master_reset_n [*5] |-> !stack_empty_n && stack_full_n)
    else $error("master reset left stack not empty");
  a_flags_excl: assert property (stack_full_n || stack_empty_n)
    else $error("full and empty both asserted");
  a_flags_hold: assert property (
    (instr_bit_low && master_reset_n) [*8] |-> $stable(stack_full_n) && $stable(stack_empty_n))
    else $error("flags moved during branch or fetch");
endmodule

// file: test/test_program_counter_stack.sv
// self-checking bench: controller and stack slice joined by the link
// assumes one clk_sys for both ends; link clock made by the controller
module test_program_counter_stack;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys;
  logic       reset_n;
  logic       cmd_valid;
  logic [1:0] cmd_op;
  logic [3:0] cmd_data;
  logic       cmd_clear;
  logic       auto_inc;
  logic       read_enable;
  logic       cmd_ready;
  logic       cmd_refused;
  logic       fetch_valid;
  logic [3:0] fetch_addr;
  logic [3:0] stack_top;
  logic       full;
  logic       empty;
  logic [3:0] mem [16];
  logic [3:0] sp;
  logic [3:0] got_addr;
  int         n_fetch;
  int         n_refused;
  int         err_count;
  int         n_tests;

  stack_link_if lk();
  program_counter_stack u_program_counter_stack (.clk_sys(clk_sys), .reset_n(reset_n),
    .link(lk));
  stack_controller u_stack_controller (.clk_sys(clk_sys), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_clear(cmd_clear),
    .auto_inc(auto_inc), .read_enable(read_enable), .cmd_ready(cmd_ready),
    .cmd_refused(cmd_refused), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .stack_top(stack_top), .full(full), .empty(empty), .link(lk));
  stack_link_checker u_stack_link_checker (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk(lk.clk), .execute_n(lk.execute_n), .instr_bit_high(lk.instr_bit_high),
    .instr_bit_low(lk.instr_bit_low), .master_reset_n(lk.master_reset_n),
    .carry_in_n(lk.carry_in_n), .out_enable_n(lk.out_enable_n),
    .stack_out_oe(lk.stack_out_oe), .fetch_addr_oe(lk.fetch_addr_oe),
    .carry_out_n(lk.carry_out_n), .stack_full_n(lk.stack_full_n),
    .stack_empty_n(lk.stack_empty_n));

  always #2 clk_sys = ~clk_sys;

  // pulses caught at the falling edge, where they are settled
  always @(negedge clk_sys)
  begin
    if (fetch_valid === 1'h1)
    begin
      got_addr <= fetch_addr;
      n_fetch <= n_fetch + 1;
    end
    if (cmd_refused === 1'h1)
      n_refused <= n_refused + 1;
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("errors %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one ready pulse per link period; bounded wait
  task automatic wait_ready();
    int k;
    k = 0;
    while (cmd_ready !== 1'h1 && k < 40)
    begin
      @(negedge clk_sys);
      k++;
    end
    chk({3'h0, cmd_ready}, 4'h1);
    @(negedge clk_sys);
  endtask

  // issue one command, let two periods pass, then compare with the model
  task automatic op(input pc_stack_pkg::op_t o, input logic [3:0] d, input logic clr);
    logic rf;
    int   nf;
    int   nr;
    rf = (o == pc_stack_pkg::OP_CALL && sp == 4'hf) ||
         (o == pc_stack_pkg::OP_RETURN && sp == 4'h0);
    nf = n_fetch;
    nr = n_refused;
    @(negedge clk_sys);
    cmd_op = o;
    cmd_data = d;
    cmd_clear = clr;
    cmd_valid = 1'h1;
    wait_ready();
    cmd_valid = 1'h0;
    cmd_clear = 1'h0;
    wait_ready();
    wait_ready();
    if (clr)
      sp = 4'h0;
    if (rf)
      chk(4'(n_refused - nr), 4'h1);
    else
    begin
      case (o)
        pc_stack_pkg::OP_RETURN: sp = sp - 4'h1;
        pc_stack_pkg::OP_BRANCH: mem[sp] = d;
        pc_stack_pkg::OP_CALL:
        begin
          sp = sp + 4'h1;
          mem[sp] = d;
        end
        default:
        begin
          chk(4'(n_fetch - nf), 4'h1);
          chk(got_addr, mem[sp]);
          mem[sp] = mem[sp] + {3'h0, auto_inc};
        end
      endcase
    end
    if (read_enable)
    begin
      chk(stack_top, mem[sp]);
      chk(lk.stack_out_n, ~mem[sp]);
    end
    chk({3'h0, lk.stack_out_oe}, {3'h0, read_enable});
    chk({2'h0, full, empty}, {2'h0, sp == 4'hf, sp == 4'h0});
    chk({3'h0, lk.carry_out_n}, {3'h0, !(auto_inc && mem[sp] == 4'hf)});
    chk({3'h0, lk.fetch_addr_oe}, 4'h0);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    summarize();
  end

  initial
  begin
    clk_sys = 1'h0;
    reset_n = 1'h0;
    cmd_valid = 1'h0;
    cmd_op = 2'h3;
    cmd_data = 4'h0;
    cmd_clear = 1'h0;
    auto_inc = 1'h1;
    read_enable = 1'h1;
    sp = 4'h0;
    n_fetch = 0;
    n_refused = 0;
    err_count = 0;
    n_tests = 0;
    foreach (mem[i])
      mem[i] = 4'h0;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'h1;
    op(pc_stack_pkg::OP_FETCH, 4'h0, 1'h0);
    op(pc_stack_pkg::OP_FETCH, 4'h0, 1'h0);
    auto_inc = 1'h0;
    // iterative fetch keeps the counter
    op(pc_stack_pkg::OP_FETCH, 4'h0, 1'h0);
    auto_inc = 1'h1;
    op(pc_stack_pkg::OP_BRANCH, 4'he, 1'h0);
    op(pc_stack_pkg::OP_FETCH, 4'h0, 1'h0);
    op(pc_stack_pkg::OP_FETCH, 4'h0, 1'h0);
    for (int i = 1; i < 16; i++)
    begin
      op(pc_stack_pkg::OP_CALL, 4'(i), 1'h0);
      if (i == 3)
        op(pc_stack_pkg::OP_FETCH, 4'h0, 1'h0);
    end
    // full stack: controller refuses a further push
    op(pc_stack_pkg::OP_CALL, 4'h5, 1'h0);
    read_enable = 1'h0;
    op(pc_stack_pkg::OP_BRANCH, 4'h9, 1'h0);
    read_enable = 1'h1;
    for (int i = 0; i < 15; i++)
      op(pc_stack_pkg::OP_RETURN, 4'h0, 1'h0);
    op(pc_stack_pkg::OP_RETURN, 4'h0, 1'h0);
    op(pc_stack_pkg::OP_CALL, 4'h3, 1'h0);
    op(pc_stack_pkg::OP_BRANCH, 4'h0, 1'h1);
    summarize();
  end
endmodule
